// ### core/dcrd_params.svh
// Constants of the diskette command and result decoder: offsets, fields, counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCRD_PARAMS_SVH
`define DCRD_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DCRD_REG_STAT 2'h0
`define DCRD_REG_DATA 2'h1
`define DCRD_REG_TIMING 2'h2
`define DCRD_REG_DRIVE 2'h3

// ****************************************
// Opcodes, command lengths and result lengths
// ****************************************
`define DCRD_OP_WDEL 6'h09
`define DCRD_OP_FMT 6'h0D
`define DCRD_OP_RECAL 8'h07
`define DCRD_OP_SINT 8'h08
`define DCRD_OP_SPEC 8'h03
`define DCRD_OP_SDRV 8'h04
`define DCRD_OP_SEEK 8'h0F
`define DCRD_LEN_WDEL 4'h9
`define DCRD_LEN_FMT 4'h6
`define DCRD_LEN_RECAL 4'h2
`define DCRD_LEN_SINT 4'h1
`define DCRD_LEN_SPEC 4'h3
`define DCRD_LEN_SDRV 4'h2
`define DCRD_LEN_SEEK 4'h3
`define DCRD_RES_LONG 3'h7
`define DCRD_RES_SINT 3'h2
`define DCRD_RES_ONE 3'h1

// ****************************************
// Status byte fields
// ****************************************
`define DCRD_CODE_NORMAL 2'h0
`define DCRD_CODE_ABORT 2'h1
`define DCRD_CODE_INVALID 2'h2
`define DCRD_ST0_SE 5
`define DCRD_ST0_EC 4
`define DCRD_ST1_NW 1
`define DCRD_STAT_RQM 7
`define DCRD_STAT_DIO 6
`define DCRD_STAT_EXEC 5
`define DCRD_STAT_BUSY 4
`define DCRD_STAT_IRQ 0

// ****************************************
// Timing
// ****************************************
`define DCRD_RECAL_MAX 7'h50
`define DCRD_CLK_NS 40
`define DCRD_MS_NS 1000000
`define DCRD_MS_CYCLES (`DCRD_MS_NS / `DCRD_CLK_NS)

`endif

// ### core/dcrd_pkg.sv
// Types of the diskette command and result decoder.
// Assumes nothing of its surroundings.
package dcrd_pkg;

    // Phase of the command sequencer, Gray along idle-cmd-exec-result
    typedef enum logic [1:0] {
        DCRD_IDLE = 2'b00,
        DCRD_CMD = 2'b01,
        DCRD_EXEC = 2'b11,
        DCRD_RES = 2'b10
    } dcrd_state_t;

    // Decoded command kind
    typedef enum logic [2:0] {
        DCRD_K_NONE = 3'h0,
        DCRD_K_WDEL = 3'h1,
        DCRD_K_FMT = 3'h2,
        DCRD_K_RECAL = 3'h3,
        DCRD_K_SINT = 3'h4,
        DCRD_K_SPEC = 3'h5,
        DCRD_K_SDRV = 3'h6,
        DCRD_K_SEEK = 3'h7
    } dcrd_kind_t;

endpackage

// ### core/dcrd_sync.sv
// Three-stage synchroniser for a pin input; output follows once stages two and three agree.
// Assumes a reset already synchronised to clk.
`timescale 1ns/100ps
`default_nettype none

module dcrd_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and clean level
    input wire logic din,
    output logic dout
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only when two settled stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= RESET_VAL;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end

endmodule // dcrd_sync

`default_nettype wire

// ### core/dcrd_tick.sv
// Divider giving a one-cycle enable pulse every DIV clocks.
// Assumes a reset already synchronised to clk.
`timescale 1ns/100ps
`default_nettype none

module dcrd_tick #(
    parameter int unsigned DIV = 25000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Enable pulse
    output logic tick
);

    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;

    // Free-running count, pulse on wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

endmodule // dcrd_tick

`default_nettype wire

// ### core/dcrd_top.sv
// Diskette command/result sequencer: takes command bytes, moves the head, returns result bytes.
// Assumes a host on the plain register port and active-low drive sense pins.
//
// Contract
// R1: Deleted-data write takes nine bytes and answers with three status bytes then C, H, R, N.
// R2: Track format takes six bytes and answers with three status bytes then four reserved bytes.
// R3: Recalibrate takes two bytes, the head bit forced to zero, and returns nothing.
// R4: Interrupt status query is one byte and answers with status byte zero and the current track.
// R5: Timing setup takes three bytes: step interval and unload delay, then load delay and no-DMA flag.
// R6: Drive status query takes two bytes and answers with the drive report byte.
// R7: Seek takes an opcode, a select byte and a target track byte and returns nothing.
// R8: An unknown opcode yields one status byte marked never started and starts nothing.
// R9: Status byte zero bits 7:6 give the ending: normal, aborted, invalid, reserved.
// R10: Status byte zero bit 5 is set when a seek completes.
// R11: Recalibrate sets status byte zero bit 4 if track zero is not seen after 80 steps.
// R12: Status byte zero bit 2 gives the head at interrupt and bit 3 reads zero.
// R13: Status byte zero bits 1:0 give the drive at interrupt.
// R14: Status byte one bit 1 is set when the drive is write protected during a write or format.
// R15: The drive report byte gives write protect in bit 6, track zero in 4, head in 2, drive in 1:0.
// R16: Command bytes are taken in order, results must be drained first, don't-care bits are ignored.
// R17: The third seek byte is the target track; the drive steps there and then interrupts.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dcrd_params.svh"

module dcrd_top #(
    parameter int unsigned MS_CYCLES = `DCRD_MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Drive sense pins
    input wire logic write_locked_flag_n,
    input wire logic track_zero_input_n,
    // Drive control pins
    output logic step_pulse,
    output logic step_dir,
    output logic head_number,
    output logic unit_sel_bit1,
    output logic unit_sel_bit0,
    // Completion event
    output logic irq
);

    // ****************************************
    // Reset release and helpers
    // ****************************************
    logic rst_meta_q;
    logic rst_sync_n;
    logic ms_tick;
    logic wp_n_s;
    logic tz_n_s;

    // Release reset through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    dcrd_tick #(.DIV(MS_CYCLES)) u_ms (
        .clk(clk),
        .rst_n(rst_sync_n),
        .tick(ms_tick)
    );

    dcrd_sync #(.RESET_VAL(1'b1)) u_wp (
        .clk(clk),
        .rst_n(rst_sync_n),
        .din(write_locked_flag_n),
        .dout(wp_n_s)
    );

    dcrd_sync #(.RESET_VAL(1'b1)) u_tz (
        .clk(clk),
        .rst_n(rst_sync_n),
        .din(track_zero_input_n),
        .dout(tz_n_s)
    );

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic dcrd_pkg::dcrd_kind_t kind_of(input logic [7:0] b);
        dcrd_pkg::dcrd_kind_t k;
        k = dcrd_pkg::DCRD_K_NONE;
        if (b[5:0] == `DCRD_OP_WDEL) k = dcrd_pkg::DCRD_K_WDEL; // [R1]
        else if (!b[7] && b[5:0] == `DCRD_OP_FMT) k = dcrd_pkg::DCRD_K_FMT; // [R2]
        else if (b == `DCRD_OP_RECAL) k = dcrd_pkg::DCRD_K_RECAL; // [R3]
        else if (b == `DCRD_OP_SINT) k = dcrd_pkg::DCRD_K_SINT; // [R4]
        else if (b == `DCRD_OP_SPEC) k = dcrd_pkg::DCRD_K_SPEC; // [R5]
        else if (b == `DCRD_OP_SDRV) k = dcrd_pkg::DCRD_K_SDRV; // [R6]
        else if (b == `DCRD_OP_SEEK) k = dcrd_pkg::DCRD_K_SEEK; // [R7]
        return k;
    endfunction

    function automatic logic [3:0] len_of(input dcrd_pkg::dcrd_kind_t k);
        logic [3:0] n;
        n = 4'h0;
        case (k)
            dcrd_pkg::DCRD_K_WDEL: n = `DCRD_LEN_WDEL; // [R1]
            dcrd_pkg::DCRD_K_FMT: n = `DCRD_LEN_FMT; // [R2]
            dcrd_pkg::DCRD_K_RECAL: n = `DCRD_LEN_RECAL; // [R3]
            dcrd_pkg::DCRD_K_SINT: n = `DCRD_LEN_SINT; // [R4]
            dcrd_pkg::DCRD_K_SPEC: n = `DCRD_LEN_SPEC; // [R5]
            dcrd_pkg::DCRD_K_SDRV: n = `DCRD_LEN_SDRV; // [R6]
            dcrd_pkg::DCRD_K_SEEK: n = `DCRD_LEN_SEEK; // [R7]
            default: n = 4'h0;
        endcase
        return n;
    endfunction

    // ****************************************
    // Sequencer state
    // ****************************************
    dcrd_pkg::dcrd_state_t state_q;
    dcrd_pkg::dcrd_kind_t kind_q;
    logic [7:0] cmd_q [0:8];
    logic [3:0] cnt_q;
    logic [3:0] need_q;
    logic [7:0] res_q [0:6];
    logic [2:0] res_len_q;
    logic [2:0] res_idx_q;
    logic move_start_q;
    logic move_done_q;
    logic move_fault_q;
    logic int_pend_q;
    logic [7:0] int_st0_q;
    logic [1:0] int_unit_q;
    logic [7:0] pcn_q [0:3];
    logic [3:0] step_interval_q;
    logic [3:0] unload_delay_q;
    logic [6:0] load_delay_q;
    logic no_dma_flag_q;

    logic wr_data;
    logic rd_data;
    logic wp;
    logic tz;
    logic [7:0] st3;
    logic [7:0] st0_now;
    dcrd_pkg::dcrd_kind_t kind_in;

    // Strobe decode and live drive report
    assign wr_data = reg_wr && (reg_addr == `DCRD_REG_DATA);
    assign rd_data = reg_rd && (reg_addr == `DCRD_REG_DATA);
    assign wp = !wp_n_s;
    assign tz = !tz_n_s;
    assign kind_in = kind_of(reg_wdata);
    assign st3 = {1'b0, wp, 1'b0, tz, 1'b0, head_number, unit_sel_bit1, unit_sel_bit0}; // [R15]
    // Write-type outcome: aborted when protected, bit 3 held zero
    assign st0_now = {(wp ? `DCRD_CODE_ABORT : `DCRD_CODE_NORMAL), 3'b000,
                      head_number, unit_sel_bit1, unit_sel_bit0}; // [R9] [R12] [R13]

    // Command intake, execution dispatch and result drain
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= dcrd_pkg::DCRD_IDLE;
            kind_q <= dcrd_pkg::DCRD_K_NONE;
            cnt_q <= 4'h0;
            need_q <= 4'h0;
            res_len_q <= 3'h0;
            res_idx_q <= 3'h0;
            move_start_q <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                cmd_q[i] <= 8'h00;
            end
            for (int i = 0; i < 7; i++) begin
                res_q[i] <= 8'h00;
            end
        end else begin
            move_start_q <= 1'b0;
            case (state_q)
                dcrd_pkg::DCRD_IDLE: begin
                    if (wr_data) begin
                        cmd_q[0] <= reg_wdata;
                        kind_q <= kind_in;
                        cnt_q <= 4'h1;
                        need_q <= len_of(kind_in);
                        res_idx_q <= 3'h0;
                        if (kind_in == dcrd_pkg::DCRD_K_NONE) begin
                            // Nothing is started; one byte says so
                            res_q[0] <= {`DCRD_CODE_INVALID, 6'h00}; // [R8] [R9]
                            res_len_q <= `DCRD_RES_ONE;
                            state_q <= dcrd_pkg::DCRD_RES;
                        end else if (kind_in == dcrd_pkg::DCRD_K_SINT) begin
                            state_q <= dcrd_pkg::DCRD_EXEC; // [R4]
                        end else begin
                            state_q <= dcrd_pkg::DCRD_CMD;
                        end
                    end
                end
                dcrd_pkg::DCRD_CMD: begin
                    // Bytes land at the next slot, strictly in order
                    if (wr_data) begin
                        cmd_q[cnt_q] <= reg_wdata; // [R16]
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q + 4'h1 == need_q) begin
                            state_q <= dcrd_pkg::DCRD_EXEC;
                            move_start_q <= (kind_q == dcrd_pkg::DCRD_K_SEEK) ||
                                            (kind_q == dcrd_pkg::DCRD_K_RECAL);
                        end
                    end
                end
                dcrd_pkg::DCRD_EXEC: begin
                    case (kind_q)
                        dcrd_pkg::DCRD_K_WDEL, dcrd_pkg::DCRD_K_FMT: begin
                            res_q[0] <= st0_now;
                            res_q[1] <= {6'h00, wp, 1'b0}; // [R14]
                            res_q[2] <= 8'h00;
                            if (kind_q == dcrd_pkg::DCRD_K_WDEL) begin
                                res_q[3] <= cmd_q[2]; // [R1]
                                res_q[4] <= cmd_q[3];
                                res_q[5] <= cmd_q[4];
                                res_q[6] <= cmd_q[5];
                            end else begin
                                res_q[3] <= 8'h00; // [R2]
                                res_q[4] <= 8'h00;
                                res_q[5] <= 8'h00;
                                res_q[6] <= 8'h00;
                            end
                            res_len_q <= `DCRD_RES_LONG;
                            state_q <= dcrd_pkg::DCRD_RES;
                        end
                        dcrd_pkg::DCRD_K_SINT: begin
                            // No pending event reads as an invalid query
                            res_q[0] <= int_pend_q ? int_st0_q : {`DCRD_CODE_INVALID, 6'h00}; // [R4]
                            res_q[1] <= pcn_q[int_unit_q];
                            res_len_q <= `DCRD_RES_SINT;
                            state_q <= dcrd_pkg::DCRD_RES;
                        end
                        dcrd_pkg::DCRD_K_SDRV: begin
                            res_q[0] <= st3; // [R6]
                            res_len_q <= `DCRD_RES_ONE;
                            state_q <= dcrd_pkg::DCRD_RES;
                        end
                        dcrd_pkg::DCRD_K_SEEK, dcrd_pkg::DCRD_K_RECAL: begin
                            // No result phase; the pending event reports the end
                            if (move_done_q) begin
                                state_q <= dcrd_pkg::DCRD_IDLE; // [R3] [R7]
                            end
                        end
                        default: begin
                            state_q <= dcrd_pkg::DCRD_IDLE; // [R5]
                        end
                    endcase
                end
                dcrd_pkg::DCRD_RES: begin
                    // New commands wait until the last result byte is read
                    if (rd_data) begin
                        res_idx_q <= res_idx_q + 3'h1;
                        if (res_idx_q + 3'h1 == res_len_q) begin
                            state_q <= dcrd_pkg::DCRD_IDLE; // [R16]
                        end
                    end
                end
                default: begin
                    state_q <= dcrd_pkg::DCRD_IDLE;
                end
            endcase
        end
    end

    // Drive and head select follow the select byte; recalibrate and timing setup force the head to zero, setup keeps the drive
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            head_number <= 1'b0;
            unit_sel_bit1 <= 1'b0;
            unit_sel_bit0 <= 1'b0;
        end else if (state_q == dcrd_pkg::DCRD_CMD && wr_data && cnt_q == 4'h1) begin
            head_number <= (kind_q == dcrd_pkg::DCRD_K_SPEC || kind_q == dcrd_pkg::DCRD_K_RECAL) ?
                           1'b0 : reg_wdata[2]; // [R3] [R16]
            if (kind_q != dcrd_pkg::DCRD_K_SPEC) begin
                unit_sel_bit1 <= reg_wdata[1];
                unit_sel_bit0 <= reg_wdata[0];
            end
        end
    end

    // ****************************************
    // Timing setup
    // ****************************************
    // Captured when the setup command reaches execution
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            step_interval_q <= 4'h0;
            unload_delay_q <= 4'h0;
            load_delay_q <= 7'h00;
            no_dma_flag_q <= 1'b0;
        end else if (state_q == dcrd_pkg::DCRD_EXEC && kind_q == dcrd_pkg::DCRD_K_SPEC) begin
            step_interval_q <= cmd_q[1][7:4]; // [R5]
            unload_delay_q <= cmd_q[1][3:0];
            load_delay_q <= cmd_q[2][7:1];
            no_dma_flag_q <= cmd_q[2][0];
        end
    end

    // ****************************************
    // Head motion
    // ****************************************
    logic moving_q;
    logic [6:0] steps_q;
    logic [3:0] wait_q;
    logic [1:0] unit_now;
    logic [7:0] target;

    assign unit_now = {unit_sel_bit1, unit_sel_bit0};
    assign target = cmd_q[2]; // [R17]

    // One step per 16 minus step interval ms ticks, at least two so each pulse falls
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            moving_q <= 1'b0;
            steps_q <= 7'h00;
            wait_q <= 4'h0;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
            move_done_q <= 1'b0;
            move_fault_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                pcn_q[i] <= 8'h00;
            end
        end else begin
            move_done_q <= 1'b0;
            move_fault_q <= 1'b0;
            if (move_start_q) begin
                moving_q <= 1'b1;
                steps_q <= 7'h00;
                wait_q <= 4'h0;
            end else if (moving_q && ms_tick) begin
                step_pulse <= 1'b0;
                if (wait_q != 4'h0) begin
                    wait_q <= wait_q - 4'h1;
                end else if (step_pulse) begin // Pulse falls on this tick; otherwise fast steps merge
                end else if (kind_q == dcrd_pkg::DCRD_K_RECAL) begin
                    if (tz) begin
                        pcn_q[unit_now] <= 8'h00;
                        moving_q <= 1'b0;
                        move_done_q <= 1'b1;
                    end else if (steps_q == `DCRD_RECAL_MAX) begin
                        // Track zero never seen
                        moving_q <= 1'b0;
                        move_done_q <= 1'b1;
                        move_fault_q <= 1'b1; // [R11]
                    end else begin
                        step_pulse <= 1'b1;
                        step_dir <= 1'b0;
                        steps_q <= steps_q + 7'h01;
                        wait_q <= 4'hF - step_interval_q;
                    end
                end else if (pcn_q[unit_now] == target) begin
                    moving_q <= 1'b0;
                    move_done_q <= 1'b1; // [R17]
                end else begin
                    step_pulse <= 1'b1;
                    step_dir <= (target > pcn_q[unit_now]);
                    pcn_q[unit_now] <= (target > pcn_q[unit_now]) ?
                                       pcn_q[unit_now] + 8'h01 : pcn_q[unit_now] - 8'h01;
                    wait_q <= 4'hF - step_interval_q;
                end
            end
        end
    end

    // ****************************************
    // Pending event and outcome byte
    // ****************************************
    // A new completion wins over the query that clears the old one
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_pend_q <= 1'b0;
            int_st0_q <= 8'h00;
            int_unit_q <= 2'h0;
            irq <= 1'b0;
        end else if (move_done_q) begin
            int_pend_q <= 1'b1;
            irq <= 1'b1;
            int_unit_q <= unit_now;
            int_st0_q <= {(move_fault_q ? `DCRD_CODE_ABORT : `DCRD_CODE_NORMAL), // [R9]
                          1'b1, // [R10]
                          move_fault_q, // [R11]
                          1'b0, head_number, // [R12]
                          unit_now}; // [R13]
        end else if (state_q == dcrd_pkg::DCRD_EXEC && kind_q == dcrd_pkg::DCRD_K_SINT) begin
            int_pend_q <= 1'b0;
            irq <= 1'b0;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `DCRD_REG_STAT: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[`DCRD_STAT_RQM] <= (state_q != dcrd_pkg::DCRD_EXEC);
                    reg_rdata[`DCRD_STAT_DIO] <= (state_q == dcrd_pkg::DCRD_RES);
                    reg_rdata[`DCRD_STAT_EXEC] <= (state_q == dcrd_pkg::DCRD_EXEC);
                    reg_rdata[`DCRD_STAT_BUSY] <= (state_q != dcrd_pkg::DCRD_IDLE);
                    reg_rdata[`DCRD_STAT_IRQ] <= int_pend_q;
                end
                `DCRD_REG_DATA: begin
                    reg_rdata <= (state_q == dcrd_pkg::DCRD_RES) ? res_q[res_idx_q] : 8'h00;
                end
                `DCRD_REG_TIMING: begin
                    reg_rdata <= {step_interval_q, unload_delay_q};
                end
                `DCRD_REG_DRIVE: begin
                    reg_rdata <= st3; // [R15]
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // dcrd_top

`default_nettype wire

// ### tb/dcrd_drive.sv
// Drive model: head position, track-zero and write-protect pins.
// Assumes one step_pulse rise per step.
`timescale 1ns/100ps
`default_nettype none

module dcrd_drive (
    // Motion
    input wire logic step_pulse,
    input wire logic step_dir,
    // Faults
    input wire logic lock,
    input wire logic stuck,
    // Sense pins
    output logic track_zero_input_n,
    output logic write_locked_flag_n
);
    int pos = 3; // Off track zero so recalibrate must step
    // Step once direction has settled, end stop at zero
    always @(posedge step_pulse) begin
        #1 pos <= step_dir ? pos + 1 : (pos > 0 ? pos - 1 : 0);
    end
    // Stuck sensor never shows zero
    assign track_zero_input_n = !(pos == 0 && !stuck);
    assign write_locked_flag_n = !lock;
endmodule // dcrd_drive
`default_nettype wire

// ### tb/dcrd_test.sv
// Self-checking bench of the command and result decoder.
// Assumes design, checker and drive model compiled first.
`timescale 1ns/100ps
`default_nettype none

module diskette_command_result_decoder_test;
    typedef struct {logic [1:0] env; int nc; logic [71:0] cb; int nr; logic [55:0] rb;} dcrd_row_t;
    logic clk, rst_n, reg_wr, reg_rd, lock, stuck, step_pulse, step_dir, irq;
    logic write_locked_flag_n, track_zero_input_n, head_number, unit_sel_bit1, unit_sel_bit0;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    int n_mismatch = 0;
    int checks_done = 0;
    // Rows: faults {lock, stuck}, command bytes, result bytes
    dcrd_row_t rows[12] = '{
        '{2'h0, 3, 72'h03F002, 0, 56'h0},
        '{2'h0, 2, 72'h0705, 0, 56'h0},
        '{2'h0, 1, 72'h08, 2, 56'h2100},
        '{2'h0, 3, 72'h0F0405, 0, 56'h0},
        '{2'h0, 1, 72'h08, 2, 56'h2405},
        '{2'h0, 2, 72'h0405, 1, 56'h05},
        '{2'h0, 9, 72'hC90211000302121BFF, 7, 56'h02000011000302},
        '{2'h2, 6, 72'h4D01020954E6, 7, 56'h41020000000000},
        '{2'h2, 2, 72'h0401, 1, 56'h41},
        '{2'h0, 1, 72'h1F, 1, 56'h80},
        '{2'h1, 2, 72'h0702, 0, 56'h0},
        '{2'h1, 1, 72'h08, 2, 56'h7200}};

    dcrd_top #(.MS_CYCLES(4)) uut (.*);
    dcrd_drive drive (.*);

    // Clock, 40 ns period
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // One register cycle, read data caught mid-cycle
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        @(negedge clk);
        q = reg_rdata;
    endtask

    // Exact compare; an unknown seen never matches
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] q);
        checks_done++;
        if (q !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, q);
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected run
    initial begin
        #2000000;
        n_mismatch++;
        conclude;
    end

    initial begin
        rst_n = 1'h0;
        {reg_wr, reg_rd, lock, stuck} = 4'h0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        foreach (rows[i]) begin
            {lock, stuck} <= rows[i].env;
            repeat (8) @(posedge clk);
            for (int k = 0; k < rows[i].nc; k++) bus(1'h1, 2'h1, rows[i].cb[8*(rows[i].nc-1-k) +: 8], v);
            v = 8'h00;
            for (int t = 0; t < 3000 && !v[7]; t++) bus(1'h0, 2'h0, 8'h00, v);
            chk("ready", 8'h80, v & 8'h80);
            for (int k = 0; k < rows[i].nr; k++) begin
                bus(1'h0, 2'h1, 8'h00, v);
                chk("result", rows[i].rb[8*(rows[i].nr-1-k) +: 8], v);
            end
        end
        bus(1'h0, 2'h1, 8'h00, v);
        chk("idle data", 8'h00, v);
        bus(1'h1, 2'h0, 8'hFF, v);
        bus(1'h0, 2'h0, 8'h00, v);
        chk("status", 8'h80, v);
        bus(1'h0, 2'h2, 8'h00, v);
        chk("timing", 8'hF0, v);
        conclude;
    end
endmodule // diskette_command_result_decoder_test

bind dcrd_top dcrd_top_chk chk_i (.*);
`default_nettype wire

// ### tb/dcrd_top_chk.sv
// Port checks of the command and result decoder.
// Assumes a bind to dcrd_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module dcrd_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Drive pins and event
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic unit_sel_bit0,
    input wire logic irq
);
    // One domain, so clock and reset once
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_stat_irq; reg_rd && reg_addr == 2'h0 |=> reg_rdata[0] == $past(irq); endproperty
    a_stat_irq: assert property (p_stat_irq) else $error("status event bit");
    property p_rep_rsv; reg_rd && reg_addr == 2'h3 |=> {reg_rdata[7], reg_rdata[5], reg_rdata[3]} == 3'h0; endproperty
    a_rep_rsv: assert property (p_rep_rsv) else $error("report spare bits");
    property p_rep_sel; reg_rd && reg_addr == 2'h3 |=> reg_rdata[0] == $past(unit_sel_bit0); endproperty
    a_rep_sel: assert property (p_rep_sel) else $error("report drive bit");
    property p_step_len; $rose(step_pulse) |=> step_pulse [*2]; endproperty
    a_step_len: assert property (p_step_len) else $error("step too short");
    property p_step_dir; step_pulse && $past(step_pulse) |-> $stable(step_dir); endproperty
    a_step_dir: assert property (p_step_dir) else $error("direction moved");
    property p_step_sel; step_pulse && $past(step_pulse) |-> $stable(unit_sel_bit0); endproperty
    a_step_sel: assert property (p_step_sel) else $error("drive moved");
    property p_irq_clr; irq && reg_wr && reg_addr == 2'h1 && reg_wdata == 8'h08 |-> ##[1:4] !irq; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("event not cleared");
endmodule // dcrd_top_chk
`default_nettype wire
